// [adrc_ctrl.sv]
// Controller driving a 1M x 8 asynchronous DRAM module through its pins.
// Assumes dq_i is already synchronous to clock_i; one clock domain.
// Contract
// - Hold both strobes high 200 us after reset, then eight RAS-only cycles.
// - Using internal refresh counter: eight CAS-before-RAS cycles replace RAS-only ones.
// - Twenty address bits: ten row with RAS, then ten column with CAS.
// - Row address stable by RAS fall, column address stable by CAS fall.
// - WE high means read, WE low means write.
// - Write: WE low before CAS falls; data captured on CAS fall.
// - Minimum RAS-to-CAS delay is row hold plus two transitions plus setup.
// - Read meets one read hold; write meets write command setup.
// - Write meets write-to-RAS, write-to-CAS and address-to-RAS lead times.
// - Page read keeps RAS low, toggles CAS with new columns, WE high.
// - Page write like page read with WE low; data captured each CAS fall.
// - All 512 rows refreshed every 8.2 ms; normal cycles refresh their row.
// - RAS-only refresh: RAS low, CAS high, row latched, data pins high-Z.
// - CAS-before-RAS needs CAS setup 0 ns and CAS hold 20 ns.
// - Hidden refresh: after read keep CAS low while RAS cycles high then low.
`timescale 1ns/10ps
`default_nettype none
`include "adrc_map.svh"
module adrc_ctrl #(
  parameter logic [15:0] POWER_CYC = 16'(`ADRC_POWER_CYC),
  parameter logic [15:0] RAS_MAX_CYC = 16'(`ADRC_RAS_MAX_CYC)
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ready_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic init_done_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [9:0] dram_addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic [7:0] dq_i
);
  adrc_pkg::adrc_state_e state_r, state_nxt;
  logic tmr_load, tmr_done;
  logic [15:0] tmr_value;
  logic [9:0] row_r, col_r, eff_row, eff_col;
  logic we_r, eff_we, take, row_hit;
  logic [7:0] wdata_r, eff_wdata;
  logic [15:0] ref_cnt_r, ras_age_r;
  logic ref_pend_r, ref_start, init_done_r, page_exp, tras_ok;
  logic [3:0] init_cnt_r;
  logic ras_n_nxt, cas_n_nxt, we_n_nxt, dq_oe_nxt;
  logic [9:0] addr_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r, ras_n_r, cas_n_r, we_n_r, dq_oe_r;
  logic [9:0] addr_r;
  logic [7:0] dq_r;

  adrc_timer #(.INIT(POWER_CYC - 16'h0001)) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_value),
    .done_o(tmr_done)
  );

  // Row from the low ten address bits, column from the high ten
  assign row_hit = (addr_i[9:0] == row_r);
  assign page_exp = (ras_age_r >= RAS_MAX_CYC - 16'h0040);
  assign tras_ok = (ras_age_r >= 16'(`ADRC_TRAS_CYC));
  always_comb begin
    ready_o = 1'b0;
    if (state_r == adrc_pkg::ADRC_IDLE) begin
      ready_o = init_done_r && !ref_pend_r;
    end else if (state_r == adrc_pkg::ADRC_OPEN) begin
      ready_o = tmr_done && row_hit && !ref_pend_r && !page_exp;
    end
  end
  assign take = req_i && ready_o;
  assign eff_we = take ? we_i : we_r;
  assign eff_row = take ? addr_i[9:0] : row_r;
  assign eff_col = take ? addr_i[19:10] : col_r;
  assign eff_wdata = take ? wdata_i : wdata_r;
  assign ref_start = (state_nxt == adrc_pkg::ADRC_CBRC) || (state_nxt == adrc_pkg::ADRC_HIDU);

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_value = 16'h0000;
    case (state_r)
      adrc_pkg::ADRC_POWER: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_IDLE;
        end
      end
      adrc_pkg::ADRC_IDLE: begin
        if (!init_done_r || ref_pend_r) begin
          state_nxt = adrc_pkg::ADRC_CBRC;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_CSR_CYC - 1);
        end else if (take) begin
          state_nxt = adrc_pkg::ADRC_ROW;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_RAH_CYC - 1);
        end
      end
      adrc_pkg::ADRC_ROW: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_CADR;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_CADR_CYC - 1);
        end
      end
      adrc_pkg::ADRC_CADR: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_COL;
          tmr_load = 1'b1;
          tmr_value = we_r ? 16'(`ADRC_WRITE_CYC - 1) : 16'(`ADRC_READ_CYC - 1);
        end
      end
      adrc_pkg::ADRC_COL: begin
        if (tmr_done && !we_r && ref_pend_r) begin
          state_nxt = adrc_pkg::ADRC_HIDU;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_RP_CYC - 1);
        end else if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_OPEN;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_CP_CYC - 1);
        end
      end
      adrc_pkg::ADRC_OPEN: begin
        if (take) begin
          state_nxt = adrc_pkg::ADRC_CADR;
          tmr_load = 1'b1;
          tmr_value = 16'h0000;
        end else if (tmr_done && tras_ok && (ref_pend_r || page_exp || req_i)) begin
          state_nxt = adrc_pkg::ADRC_PRE;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_PRE_CYC - 1);
        end
      end
      adrc_pkg::ADRC_PRE: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_IDLE;
        end
      end
      adrc_pkg::ADRC_CBRC: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_CBRR;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_TRAS_CYC - 1);
        end
      end
      adrc_pkg::ADRC_HIDU: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_HIDD;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_TRAS_CYC - 1);
        end
      end
      adrc_pkg::ADRC_CBRR, adrc_pkg::ADRC_HIDD: begin
        if (tmr_done) begin
          state_nxt = adrc_pkg::ADRC_PRE;
          tmr_load = 1'b1;
          tmr_value = 16'(`ADRC_PRE_CYC - 1);
        end
      end
      default: begin
        state_nxt = adrc_pkg::ADRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= adrc_pkg::ADRC_POWER;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      row_r <= 10'h000;
      col_r <= 10'h000;
      we_r <= 1'b0;
      wdata_r <= 8'h00;
    end else if (take) begin
      row_r <= addr_i[9:0];
      col_r <= addr_i[19:10];
      we_r <= we_i;
      wdata_r <= wdata_i;
    end
  end

  // Refresh pacing: one row every interval; a new request beats the clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_r <= 16'(`ADRC_REF_CYC - 1);
      ref_pend_r <= 1'b0;
    end else begin
      if (ref_cnt_r == 16'h0000) begin
        ref_cnt_r <= 16'(`ADRC_REF_CYC - 1);
      end else begin
        ref_cnt_r <= ref_cnt_r - 16'h0001;
      end
      if (init_done_r && ref_cnt_r == 16'h0000) begin
        ref_pend_r <= 1'b1;
      end else if (ref_start) begin
        ref_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt_r <= 4'h0;
      init_done_r <= 1'b0;
    end else if (!init_done_r && state_r == adrc_pkg::ADRC_CBRR && tmr_done) begin
      init_cnt_r <= init_cnt_r + 4'h1;
      init_done_r <= (init_cnt_r == 4'(`ADRC_INIT_CYCLES - 1));
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ras_age_r <= 16'h0000;
    end else if (ras_n_r) begin
      ras_age_r <= 16'h0000;
    end else if (ras_age_r != 16'hffff) begin
      ras_age_r <= ras_age_r + 16'h0001;
    end
  end

  always_comb begin
    ras_n_nxt = 1'b1;
    cas_n_nxt = 1'b1;
    case (state_nxt)
      adrc_pkg::ADRC_ROW, adrc_pkg::ADRC_CADR, adrc_pkg::ADRC_OPEN: ras_n_nxt = 1'b0;
      adrc_pkg::ADRC_COL, adrc_pkg::ADRC_CBRR, adrc_pkg::ADRC_HIDD: begin
        ras_n_nxt = 1'b0;
        cas_n_nxt = 1'b0;
      end
      adrc_pkg::ADRC_CBRC, adrc_pkg::ADRC_HIDU: cas_n_nxt = 1'b0;
      default: ras_n_nxt = 1'b1;
    endcase
    we_n_nxt = !(eff_we && (state_nxt == adrc_pkg::ADRC_CADR ||
                            state_nxt == adrc_pkg::ADRC_COL));
    dq_oe_nxt = !we_n_nxt;
    case (state_nxt)
      adrc_pkg::ADRC_ROW: addr_nxt = eff_row;
      adrc_pkg::ADRC_CADR, adrc_pkg::ADRC_COL: addr_nxt = eff_col;
      default: addr_nxt = addr_r;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ras_n_r <= 1'b1;
      cas_n_r <= 1'b1;
      we_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
      addr_r <= 10'h000;
      dq_r <= 8'h00;
    end else begin
      ras_n_r <= ras_n_nxt;
      cas_n_r <= cas_n_nxt;
      we_n_r <= we_n_nxt;
      dq_oe_r <= dq_oe_nxt;
      addr_r <= addr_nxt;
      dq_r <= eff_wdata;
    end
  end

  // Sample read data at the end of the access while CAS is still low
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= (state_r == adrc_pkg::ADRC_COL) && tmr_done && !we_r;
      if ((state_r == adrc_pkg::ADRC_COL) && tmr_done && !we_r) begin
        rdata_r <= dq_i;
      end
    end
  end

  assign ras_n_o = ras_n_r;
  assign cas_n_o = cas_n_r;
  assign we_n_o = we_n_r;
  assign dram_addr_o = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_o = dq_oe_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign init_done_o = init_done_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_cas_first;
    !cas_n_o && ras_n_o ##1 $fell(ras_n_o);
  endsequence
  property p_power_quiet;
    (state_r == adrc_pkg::ADRC_POWER) |-> ras_n_o && cas_n_o;
  endproperty
  a_power_quiet: assert property (p_power_quiet) else $error("strobe low in power wait");
  property p_init_count;
    $rose(init_done_o) |-> init_cnt_r == 4'h8;
  endproperty
  a_init_count: assert property (p_init_count) else $error("init ended early");
  property p_row_hold;
    $fell(ras_n_o) && cas_n_o |=> $stable(dram_addr_o);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row address moved early");
  property p_rcd_min;
    $fell(ras_n_o) && cas_n_o |-> cas_n_o[*4];
  endproperty
  a_rcd_min: assert property (p_rcd_min) else $error("RAS to CAS delay short");
  property p_cbr_hold;
    s_cas_first |-> !cas_n_o[*3];
  endproperty
  a_cbr_hold: assert property (p_cbr_hold) else $error("CAS hold after RAS short");
  property p_write_setup;
    $fell(cas_n_o) && !we_n_o && !ras_n_o |-> !$past(we_n_o) && dq_oe_o;
  endproperty
  a_write_setup: assert property (p_write_setup) else $error("WE not low before CAS");
  property p_data_hold;
    $fell(cas_n_o) && dq_oe_o |-> (dq_oe_o && $stable(dq_o))[*3];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data hold short");
  property p_read_we;
    !cas_n_o && !ras_n_o && !dq_oe_o |-> we_n_o;
  endproperty
  a_read_we: assert property (p_read_we) else $error("WE low during read");
  property p_refresh_quiet;
    (state_r == adrc_pkg::ADRC_CBRC || state_r == adrc_pkg::ADRC_CBRR) |-> !dq_oe_o;
  endproperty
  a_refresh_quiet: assert property (p_refresh_quiet) else $error("data driven in refresh");
  property p_hidden;
    $rose(ras_n_o) && !cas_n_o |-> !cas_n_o ##[1:20] $fell(ras_n_o);
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden refresh broken");
  property p_ref_taken;
    $rose(ref_pend_r) |-> ##[1:400] !ref_pend_r;
  endproperty
  a_ref_taken: assert property (p_ref_taken) else $error("refresh not started");
endmodule
`default_nettype wire

// [adrc_map.svh]
// Timing constants for the asynchronous DRAM module controller.
// Assumes a 125 MHz controller clock; all counts derive from nanosecond figures.
`ifndef ADRC_MAP_SVH
`define ADRC_MAP_SVH

`define ADRC_CLK_PS 8000
`define ADRC_CYC_RAW(ns) (((ns) * 1000 + `ADRC_CLK_PS - 1) / `ADRC_CLK_PS)
`define ADRC_CYC_UP(ns) ((`ADRC_CYC_RAW(ns) < 1) ? 1 : `ADRC_CYC_RAW(ns))
`define ADRC_CYC_DN(ns) ((((ns) * 1000) / `ADRC_CLK_PS < 1) ? 1 : ((ns) * 1000) / `ADRC_CLK_PS)

`define ADRC_T_POWER_NS 200000
`define ADRC_INIT_CYCLES 8
`define ADRC_T_REF_NS 8200000
`define ADRC_REF_ROWS 512
`define ADRC_T_RP_NS 80
`define ADRC_T_RC_NS 210
`define ADRC_T_RAS_NS 120
`define ADRC_T_RAS_MAX_NS 100000
`define ADRC_T_RAH_NS 15
`define ADRC_T_TRANS_NS 5
`define ADRC_T_ASC_NS 0
`define ADRC_T_RCD_NS (`ADRC_T_RAH_NS + 2 * `ADRC_T_TRANS_NS + `ADRC_T_ASC_NS)
`define ADRC_T_AA_NS 60
`define ADRC_T_CAS_NS 35
`define ADRC_T_CP_NS 15
`define ADRC_T_CSR_NS 0
`define ADRC_T_CHR_NS 20

`define ADRC_POWER_CYC `ADRC_CYC_UP(`ADRC_T_POWER_NS)
`define ADRC_REF_CYC `ADRC_CYC_DN(`ADRC_T_REF_NS / `ADRC_REF_ROWS)
`define ADRC_RAS_MAX_CYC `ADRC_CYC_DN(`ADRC_T_RAS_MAX_NS)
`define ADRC_TRAS_CYC `ADRC_CYC_UP(`ADRC_T_RAS_NS)
`define ADRC_PRE_NS ((`ADRC_T_RP_NS > `ADRC_T_RC_NS - `ADRC_T_RAS_NS) ? \
  `ADRC_T_RP_NS : `ADRC_T_RC_NS - `ADRC_T_RAS_NS)
`define ADRC_PRE_CYC `ADRC_CYC_UP(`ADRC_PRE_NS)
`define ADRC_RP_CYC `ADRC_CYC_UP(`ADRC_T_RP_NS)
`define ADRC_RAH_CYC `ADRC_CYC_UP(`ADRC_T_RAH_NS)
`define ADRC_RCD_CYC `ADRC_CYC_UP(`ADRC_T_RCD_NS)
`define ADRC_CADR_CYC ((`ADRC_RCD_CYC > `ADRC_RAH_CYC) ? `ADRC_RCD_CYC - `ADRC_RAH_CYC : 1)
`define ADRC_READ_CYC `ADRC_CYC_UP(`ADRC_T_AA_NS)
`define ADRC_WRITE_CYC `ADRC_CYC_UP(`ADRC_T_CAS_NS)
`define ADRC_CP_CYC `ADRC_CYC_UP(`ADRC_T_CP_NS)
`define ADRC_CSR_CYC `ADRC_CYC_UP(`ADRC_T_CSR_NS)

`endif

// [adrc_pkg.sv]
// Types shared by the DRAM module controller.
// Assumes nothing beyond a SystemVerilog compiler.
package adrc_pkg;
  typedef enum logic [3:0] {
    ADRC_POWER = 4'h0,
    ADRC_IDLE = 4'h1,
    ADRC_ROW = 4'h3,
    ADRC_CADR = 4'h2,
    ADRC_COL = 4'h6,
    ADRC_OPEN = 4'h7,
    ADRC_PRE = 4'h5,
    ADRC_CBRC = 4'h4,
    ADRC_CBRR = 4'hc,
    ADRC_HIDU = 4'hd,
    ADRC_HIDD = 4'hf
  } adrc_state_e;
  typedef logic [15:0] adrc_count_t;
endpackage

// [adrc_timer.sv]
// Down counter that times each controller state.
// Assumes the loader supplies the dwell time minus one.
`timescale 1ns/10ps
`default_nettype none
module adrc_timer #(
  parameter logic [15:0] INIT = 16'h0000
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] value_i,
  output logic done_o
);
  logic [15:0] cnt_r;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= INIT;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign done_o = (cnt_r == 16'h0000);
endmodule
`default_nettype wire

// [adrc_dram_model.sv]
// Behavioural model of the 1M x 8 DRAM module on the controller pins.
// Assumes strobes come from a clocked controller; times are in ns.
`timescale 1ns/10ps
`default_nettype none
module adrc_dram_model #(
  parameter int ACC_NS = 60,
  parameter int PWR_NS = 160
) (
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic [15:0] cbr_cnt_o,
  output logic [15:0] hid_cnt_o,
  output logic [15:0] viol_o
);
  logic [7:0] mem [bit [19:0]];
  logic [9:0] row_r = 10'h000;
  logic [8:0] ref_row_r = 9'h000;
  logic cbr_r = 1'b0;
  logic drive_r = 1'b0;
  logic [7:0] dout_r = 8'h00;
  logic [15:0] cbr_n = 16'h0000;
  logic [15:0] hid_n = 16'h0000;
  logic [15:0] viol_ras = 16'h0000;
  logic [15:0] viol_cas = 16'h0000;
  logic [15:0] viol_end = 16'h0000;
  realtime t_ras = 0;
  realtime t_cas = 0;
  realtime t_we = 0;
  // Each strobe edge process keeps its own violation count
  assign cbr_cnt_o = cbr_n;
  assign hid_cnt_o = hid_n;
  assign viol_o = viol_ras + viol_cas + viol_end;
  // Released pins show the inverse of the last value
  assign dq_o = drive_r ? dout_r : ~dout_r;
  always @(we_n_i) t_we = $realtime;
  always @(negedge ras_n_i) begin
    t_ras = $realtime;
    if (t_ras < PWR_NS) viol_ras = viol_ras + 16'h0001;
    cbr_r = !cas_n_i;
    if (cbr_r) begin
      if (drive_r) hid_n = hid_n + 16'h0001;
      ref_row_r = ref_row_r + 9'h001;
      cbr_n = cbr_n + 16'h0001;
    end else begin
      #1 row_r = addr_i;
      #14 if (addr_i !== row_r) viol_ras = viol_ras + 16'h0001;
    end
  end
  always @(negedge cas_n_i) begin
    logic [19:0] a;
    t_cas = $realtime;
    a = {addr_i, row_r};
    if (!ras_n_i && !cbr_r) begin
      if (cbr_n < 16'h0008) viol_cas = viol_cas + 16'h0001;
      if (t_cas - t_ras < 25) viol_cas = viol_cas + 16'h0001;
      if (!we_n_i) begin
        if (t_we >= t_cas) viol_cas = viol_cas + 16'h0001;
        mem[a] = dq_i;
      end else begin
        #ACC_NS;
        if (!cas_n_i) begin
          dout_r = mem[a];
          drive_r = 1'b1;
        end
      end
    end
  end
  always @(posedge cas_n_i) begin
    if (cbr_r && $realtime - t_ras < 20) viol_end = viol_end + 16'h0001;
    if (!we_n_i && $realtime - t_we < 25) viol_end = viol_end + 16'h0001;
    #7 drive_r = 1'b0;
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the DRAM module controller.
// Assumes the behavioural module model stands on the DRAM pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] PWR = 16'h0014;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [19:0] addr_i = 20'h00000;
  logic [7:0] wdata_i = 8'h00;
  logic ready_o, rvalid_o, init_done_o, ras_n_o, cas_n_o, we_n_o, dq_oe_o;
  logic [7:0] rdata_o, dq_o, mdl_dq, dq_bus;
  logic [9:0] dram_addr_o;
  logic [15:0] cbr, hid, viol;
  int n_mismatch = 0;
  int num_checks = 0;
  always #4 clock_i = ~clock_i;
  assign dq_bus = dq_oe_o ? dq_o : mdl_dq;
  adrc_ctrl #(.POWER_CYC(PWR), .RAS_MAX_CYC(16'h00c8)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .dram_addr_o(dram_addr_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .dq_i(dq_bus));
  adrc_dram_model #(.ACC_NS(60), .PWR_NS(int'(PWR) * 8)) mdl (.ras_n_i(ras_n_o),
    .cas_n_i(cas_n_o), .we_n_i(we_n_o), .addr_i(dram_addr_o), .dq_i(dq_bus), .dq_o(mdl_dq),
    .cbr_cnt_o(cbr), .hid_cnt_o(hid), .viol_o(viol));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic we, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_i);
    req_i <= 1'b1;
    we_i <= we;
    addr_i <= a;
    wdata_i <= d;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (ready_o !== 1'b1 && n < 3000);
    if (ready_o !== 1'b1) n_mismatch++;
    @(posedge clock_i);
    req_i <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    int n;
    access(1'b0, a, 8'h00);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (rvalid_o !== 1'b1 && n < 100);
    if (rvalid_o !== 1'b1) n_mismatch++;
    check({24'h0, rdata_o}, {24'h0, exp});
  endtask
  task automatic sync_refresh;
    @(negedge ras_n_o iff cas_n_o === 1'b0);
    @(posedge ras_n_o);
  endtask
  task automatic t_init;
    int n;
    n = 0;
    while (ras_n_o === 1'b1 && cas_n_o === 1'b1 && n < 1000) begin
      @(negedge clock_i);
      n++;
    end
    check(32'(n >= int'(PWR)), 32'h1);
    while (init_done_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    check({16'h0, cbr}, 32'h8);
    $display("test init done");
  endtask
  task automatic t_rw;
    logic [19:0] a [6] = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00, 20'h00401, 20'h00001};
    logic [7:0] d [6] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h81, 8'h7e};
    for (int i = 0; i < 6; i++) access(1'b1, a[i], d[i]);
    for (int i = 5; i >= 0; i--) rd(a[i], d[i]);
    access(1'b1, 20'h00000, 8'h0f);
    rd(20'h00000, 8'h0f);
    $display("test write read done");
  endtask
  task automatic t_page;
    int f;
    sync_refresh();
    f = 0;
    fork
      forever @(negedge ras_n_o) f++;
      begin
        for (int c = 0; c < 4; c++) access(1'b1, {10'(c * 341), 10'h155}, 8'(8'h11 * c));
        for (int c = 3; c >= 0; c--) rd({10'(c * 341), 10'h155}, 8'(8'h11 * c));
      end
    join_any
    disable fork;
    check(32'(f), 32'h1);
    $display("test page done");
  endtask
  task automatic t_hidden;
    logic [15:0] h;
    sync_refresh();
    h = hid;
    // First read is taken 6 cycles before the next refresh request, so it lands in COL
    repeat (1976) @(posedge clock_i);
    for (int i = 0; i < 8; i++) rd(20'hfffff, 8'h5a);
    check({16'h0, hid - h}, 32'h1);
    $display("test hidden done");
  endtask
  task automatic t_refresh;
    logic [15:0] c;
    sync_refresh();
    c = cbr;
    repeat (4032) @(posedge clock_i);
    check({16'h0, cbr - c}, 32'h2);
    $display("test refresh done");
  endtask
  initial begin
    #320000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    t_init();
    t_rw();
    t_page();
    t_hidden();
    t_refresh();
    check({16'h0, viol}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
